// ==== hw/plsim_consts.svh ====
// Offsets, field positions, reset values and masks for the link status
// and event interrupt block. Assumes byte addresses on a 32-bit bus.
`ifndef PLSIM_CONSTS_SVH
`define PLSIM_CONSTS_SVH

// Byte offsets of the registers
`define PLSIM_OFF_LINK_STAT   8'h18
`define PLSIM_OFF_EVT_EN      8'h1C
`define PLSIM_OFF_EVT_STAT    8'h20

// Reset values
`define PLSIM_RST_LINK_STAT   16'h0000
`define PLSIM_RST_EVT_EN      16'h0000
`define PLSIM_RST_EVT_STAT    16'h0000

// Writable bits of the enable register, reserved pair 7:6 held at zero
`define PLSIM_EVT_EN_WMASK    16'hFF3F
// Event bits that can ever be pending
`define PLSIM_EVT_LIVE_MASK   16'hFF3F

// Event bit positions
`define PLSIM_EV_WAKE         15
`define PLSIM_EV_ROLE_FAULT   14
`define PLSIM_EV_NP_RX        13
`define PLSIM_EV_NP_TX        12
`define PLSIM_EV_AN_FAULT     11
`define PLSIM_EV_AN_DONE      10
`define PLSIM_EV_FIFO_OVF     9
`define PLSIM_EV_REF_LOSS     8
`define PLSIM_EV_DOWNSHIFT    5
`define PLSIM_EV_POLARITY     4
`define PLSIM_EV_CROSSOVER    3
`define PLSIM_EV_DUPLEX       2
`define PLSIM_EV_SPEED        1
`define PLSIM_EV_LINK         0

`endif

// ==== hw/plsim_pkg.sv ====
// Types shared by the link status and event interrupt block.
// Assumes the consts header carries all numeric values.
package plsim_pkg;

  // Active media port encoding
  typedef enum logic [1:0] {
    PLSIM_MEDIA_TP,
    PLSIM_MEDIA_FIBER,
    PLSIM_MEDIA_MII2,
    PLSIM_MEDIA_SERIAL
  } plsim_media_t;

  // Resolved pause encoding
  typedef enum logic [1:0] {
    PLSIM_PAUSE_NONE,
    PLSIM_PAUSE_TX,
    PLSIM_PAUSE_RX,
    PLSIM_PAUSE_BOTH
  } plsim_pause_t;

  // Link speed encoding
  typedef enum logic [1:0] {
    PLSIM_SPD_10,
    PLSIM_SPD_100,
    PLSIM_SPD_1000,
    PLSIM_SPD_SPECIAL
  } plsim_speed_t;

  // Resolved link state, laid out as the low byte of the status register
  typedef struct packed {
    plsim_media_t active_media_port;
    plsim_pause_t pause_resolution;
    logic         duplex_state;
    logic         eee_resolved;
    plsim_speed_t link_speed;
  } plsim_link_t;

endpackage : plsim_pkg

// ==== hw/plsim_top.sv ====
// Link resolution status register and event interrupt enable logic,
// reached over an Avalon-MM slave with waitrequest.
// Assumes link state and event strobes come from logic on clk_sys.
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "plsim_consts.svh"

module plsim_top #(
  parameter int EVT_W = 16              // Width of event registers
) (
  input  wire logic                clk_sys,           // System clock, 200 MHz
  input  wire logic                rst_n,             // Async reset, active low
  // Avalon-MM slave
  input  wire logic [7:0]          avs_address,       // Byte address
  input  wire logic                avs_read,          // Read request
  input  wire logic                avs_write,         // Write request
  input  wire logic [31:0]         avs_writedata,     // Write data
  input  wire logic [3:0]          avs_byteenable,    // Byte lanes
  output logic      [31:0]         avs_readdata,      // Read data, registered
  output logic                     avs_waitrequest,   // Stall
  // Link state from the resolution logic
  input  wire plsim_pkg::plsim_link_t link_state,     // Resolved link fields
  input  wire logic                link_up,           // Link is up
  // Event strobes, one bit per event position
  input  wire logic [EVT_W-1:0]    event_strobe,      // One-cycle event pulses
  // Management interrupt
  output logic                     mgmt_irq_pin       // Active high, registered
);

  // Address decode, shared by read and write paths
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
    addr_hit = (a[7:2] == off[7:2]);
  endfunction : addr_hit

  // Registers
  plsim_pkg::plsim_link_t link_stat_r;   // Low byte of link status
  logic                   link_up_r;     // Previous link level
  logic [EVT_W-1:0]       evt_en_r;      // Event enable register
  logic [EVT_W-1:0]       evt_en_nxt;    // Its next value
  logic [EVT_W-1:0]       evt_stat_r;    // Pending events, sticky
  logic [EVT_W-1:0]       evt_stat_nxt;  // Its next value
  logic [31:0]            rdata_r;       // Captured read data
  logic                   ack_r;         // Second cycle of an access
  logic                   irq_r;         // Registered interrupt level

  // Bus access phases
  wire                    req_any;       // Read or write pending
  wire                    acc_done;      // Edge where access completes
  wire                    wr_done;       // Completing write
  wire                    rd_done;       // Completing read
  wire                    sel_link;      // Status register selected
  wire                    sel_en;        // Enable register selected
  wire                    sel_evt;       // Event status selected
  wire [31:0]             rdata_nxt;     // Data to capture
  wire [EVT_W-1:0]        en_wdata;      // Byte-lane merged enable data
  wire [EVT_W-1:0]        evt_set;       // Events raised this cycle
  wire [EVT_W-1:0]        evt_clr;       // Events cleared by a read
  wire [EVT_W-1:0]        evt_derived;   // Events found from state changes
  wire [EVT_W-1:0]        live_mask;     // Bits that can ever be pending
  wire                    irq_nxt;       // Interrupt level next cycle

  // Each access stalls one cycle so read data comes from a flop
  assign req_any         = avs_read | avs_write;
  assign avs_waitrequest = req_any & ~ack_r;
  assign acc_done        = req_any & ack_r;
  assign wr_done         = acc_done & avs_write;
  assign rd_done         = acc_done & avs_read;

  // Register select
  assign sel_link = addr_hit(avs_address, `PLSIM_OFF_LINK_STAT);
  assign sel_en   = addr_hit(avs_address, `PLSIM_OFF_EVT_EN);
  assign sel_evt  = addr_hit(avs_address, `PLSIM_OFF_EVT_STAT);

  // Read mux; upper byte of status and unmapped addresses read zero
  assign rdata_nxt = sel_link ? {24'h0000_00, link_stat_r} :
                     sel_en   ? {16'h0000, evt_en_r} :
                     sel_evt  ? {16'h0000, evt_stat_r} :
                                32'h0000_0000;

  // Enable write honours byte lanes; reserved pair is forced to zero
  assign en_wdata[7:0]   = avs_byteenable[0] ? avs_writedata[7:0] : evt_en_r[7:0];
  assign en_wdata[15:8]  = avs_byteenable[1] ? avs_writedata[15:8] : evt_en_r[15:8];
  assign evt_en_nxt = (wr_done & sel_en) ?
                      (en_wdata & `PLSIM_EVT_EN_WMASK) : evt_en_r;

  // Changes of duplex, speed and link level raise their own events
  assign evt_derived[`PLSIM_EV_DUPLEX] =
         link_state.duplex_state != link_stat_r.duplex_state;
  assign evt_derived[`PLSIM_EV_SPEED]  =
         link_state.link_speed != link_stat_r.link_speed;
  assign evt_derived[`PLSIM_EV_LINK]   = link_up != link_up_r;
  assign evt_derived[EVT_W-1:3]        = '0;

  // Externally detected events plus derived changes
  assign live_mask = `PLSIM_EVT_LIVE_MASK;
  assign evt_set   = (event_strobe | evt_derived) & live_mask;

  // A read clears only what it reported, so a later event survives
  assign evt_clr = (rd_done & sel_evt) ? rdata_r[EVT_W-1:0] : '0;

  // Sticky event bits, set wins over clear
  genvar gi;
  generate
    for (gi = 0; gi < EVT_W; gi++) begin : g_evt
      assign evt_stat_nxt[gi] = evt_set[gi] |
                                (evt_stat_r[gi] & ~evt_clr[gi]);
    end
  endgenerate

  // Interrupt follows pending events gated by enables
  assign irq_nxt      = |(evt_stat_nxt & evt_en_nxt);
  assign mgmt_irq_pin = irq_r;
  assign avs_readdata = rdata_r;

  // Status tracks the resolution logic every cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      // Only the low byte is stored; the reserved upper byte is never held
      link_stat_r <= plsim_pkg::plsim_link_t'(8'(`PLSIM_RST_LINK_STAT));
      link_up_r   <= 1'b0;
    end else begin
      link_stat_r <= link_state;
      link_up_r   <= link_up;
    end
  end

  // Enable and event registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      evt_en_r   <= `PLSIM_RST_EVT_EN;
      evt_stat_r <= `PLSIM_RST_EVT_STAT;
      irq_r      <= 1'b0;
    end else begin
      evt_en_r   <= evt_en_nxt;
      evt_stat_r <= evt_stat_nxt;
      irq_r      <= irq_nxt;
    end
  end

  // Bus phase; read data captured in the stall cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r   <= req_any & ~ack_r;
      if (req_any & ~ack_r) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

endmodule : plsim_top

// ==== testbench/plsim_chk.sv ====
// Checker of the bus handshake, register reads and interrupt pin.
// Assumes a master that holds each request until it is accepted.
`timescale 1ns/1ps
`include "plsim_consts.svh"
module plsim_chk #(parameter int EVT_W = 16) (
  input wire logic                   clk_sys,
  input wire logic                   rst_n,
  input wire logic [7:0]             avs_address,
  input wire logic                   avs_read,
  input wire logic                   avs_write,
  input wire logic [31:0]            avs_readdata,
  input wire logic                   avs_waitrequest,
  input wire plsim_pkg::plsim_link_t link_state,
  input wire logic                   link_up,
  input wire logic [EVT_W-1:0]       event_strobe,
  input wire logic                   mgmt_irq_pin
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire       req    = avs_read | avs_write;           // Any request
  wire       rd_acc = avs_read & ~avs_waitrequest;    // Read accept cycle
  wire       wr_acc = avs_write & ~avs_waitrequest;   // Write accept cycle
  wire [5:0] wa     = avs_address[7:2];               // Word address
  sequence s_stall; req && avs_waitrequest; endsequence
  sequence s_acc; req && !avs_waitrequest; endsequence
  AST_STALL_FIRST: assert property (req && !$past(req) |-> avs_waitrequest)
    else $error("first request cycle not stalled");
  AST_ACK_NEXT: assert property (s_stall |=> s_acc)
    else $error("request not accepted after one stall");
  AST_STAT_UPPER: assert property (rd_acc && wa == 6 |-> avs_readdata[31:8] == 0)
    else $error("status upper byte not zero");
  AST_EN_RESV: assert property (rd_acc && wa == 7 |-> avs_readdata[7:6] == 0)
    else $error("enable reserved pair not zero");
  AST_UNMAP: assert property (rd_acc && wa > 8 |-> avs_readdata == 0)
    else $error("unmapped read not zero");
  AST_CLR: assert property (rd_acc && wa == 8 && event_strobe == 0 &&
    $past(event_strobe) == 0 && $stable(link_state) && $stable(link_up) |=> !mgmt_irq_pin)
    else $error("pin not released by status read");
  AST_SRC: assert property ($rose(mgmt_irq_pin) |-> $past(event_strobe) != 0 ||
    $past(wr_acc) || $past(link_state) != $past(link_state, 2) ||
    $past(link_up) != $past(link_up, 2)) else $error("pin rose without cause");
  AST_RD_HOLD: assert property (!req |=> $stable(avs_readdata))
    else $error("read data moved while idle");
endmodule : plsim_chk
bind plsim_top plsim_chk #(.EVT_W(EVT_W)) u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .link_state(link_state), .link_up(link_up), .event_strobe(event_strobe),
  .mgmt_irq_pin(mgmt_irq_pin));

// ==== testbench/plsim_host_mon.sv ====
// Management host side: counts interrupt assertions it has to service.
// Assumes the pin is an active high level on clk_sys.
`timescale 1ns/1ps
module plsim_host_mon (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic mgmt_irq_pin,
  output int       rise_cnt
);
  logic irq_r;  // Last seen pin level
  // Each rise needs one event status read from the host
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_r    <= 1'b0;
      rise_cnt <= 0;
    end else begin
      irq_r    <= mgmt_irq_pin;
      rise_cnt <= rise_cnt + int'(mgmt_irq_pin & ~irq_r);
    end
  end
endmodule : plsim_host_mon

// ==== testbench/testbench.sv ====
// Self-checking bench of the link status and event interrupt block.
// Assumes the designer's one-stall Avalon slave timing.
`timescale 1ns/1ps
`include "plsim_consts.svh"
module testbench;
  logic                   clk_sys = 0, rst_n = 0, avs_read = 0, avs_write = 0, link_up = 0;
  logic [7:0]             avs_address = 0;
  logic [31:0]            avs_writedata = 0, avs_readdata, rd;
  logic [3:0]             avs_byteenable = 0;
  logic                   avs_waitrequest, mgmt_irq_pin;
  logic [15:0]            event_strobe = 0;
  plsim_pkg::plsim_link_t link_state = '0;
  logic [7:0]             v;
  int                     err_count = 0, num_checks = 0, rise_cnt;
  always #2.5 clk_sys = ~clk_sys;
  plsim_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link_state(link_state), .link_up(link_up),
    .event_strobe(event_strobe), .mgmt_irq_pin(mgmt_irq_pin));
  plsim_host_mon host (.clk_sys(clk_sys), .rst_n(rst_n), .mgmt_irq_pin(mgmt_irq_pin),
    .rise_cnt(rise_cnt));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  // One bus transfer, held until waitrequest is sampled low
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [3:0] be);
    int n;
    @(posedge clk_sys);
    {avs_write, avs_read} <= {wr, !wr};
    {avs_address, avs_writedata, avs_byteenable} <= {a, wd, be};
    n = 0;
    do begin @(posedge clk_sys); n++; end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin err_count++; $display("Error %0t: bus hang", $time); end
    rd = avs_readdata;
    {avs_write, avs_read} <= 2'h0;
  endtask : bus
  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'h0);
    chk(rd, exp);
  endtask : rd_chk
  task pulse(input logic [15:0] m);
    @(posedge clk_sys) event_strobe <= m;
    @(posedge clk_sys) event_strobe <= 16'h0;
  endtask : pulse
  // Reset values, and all events blocked while enables are zero
  task t_reset;
    rd_chk(`PLSIM_OFF_LINK_STAT, 32'h0);
    rd_chk(`PLSIM_OFF_EVT_EN, 32'h0);
    pulse(16'hFFFF);
    tick(2);
    chk({31'h0, mgmt_irq_pin}, 32'h0);
  endtask : t_reset
  // Every code of every field, then a write that must not stick
  task t_status;
    for (int i = 0; i < 4; i++) begin
      v = {i[1:0], i[1:0], i[0], i[1], i[1:0]};
      @(posedge clk_sys) link_state <= plsim_pkg::plsim_link_t'(v);
      tick(3);
      rd_chk(`PLSIM_OFF_LINK_STAT, {24'h0, v});
      bus(1'b1, `PLSIM_OFF_LINK_STAT, 32'hFFFF_FFFF, 4'hF);
      rd_chk(`PLSIM_OFF_LINK_STAT, {24'h0, v});
    end
  endtask : t_status
  // Reserved pair, byte lanes and an unmapped address
  task t_enable;
    bus(1'b1, `PLSIM_OFF_EVT_EN, 32'h0000_FFFF, 4'h3);
    rd_chk(`PLSIM_OFF_EVT_EN, 32'h0000_FF3F);
    bus(1'b1, `PLSIM_OFF_EVT_EN, 32'h0, 4'h1);
    rd_chk(`PLSIM_OFF_EVT_EN, 32'h0000_FF00);
    bus(1'b1, `PLSIM_OFF_EVT_EN, 32'h0, 4'h3);
    rd_chk(8'h40, 32'h0);
  endtask : t_enable
  // Pend each event masked, unmask it, then service by read
  task t_events;
    bus(1'b0, `PLSIM_OFF_EVT_STAT, 32'h0, 4'h0);
    for (int b = 0; b < 16; b++) if (b != 6 && b != 7) begin
      pulse(16'h1 << b);
      tick(2);
      chk({31'h0, mgmt_irq_pin}, 32'h0);
      bus(1'b1, `PLSIM_OFF_EVT_EN, 32'h1 << b, 4'h3);
      tick(1);
      chk({31'h0, mgmt_irq_pin}, 32'h1);
      rd_chk(`PLSIM_OFF_EVT_STAT, 32'h1 << b);
      tick(2);
      chk({31'h0, mgmt_irq_pin}, 32'h0);
      bus(1'b1, `PLSIM_OFF_EVT_EN, 32'h0, 4'h3);
    end
    bus(1'b1, `PLSIM_OFF_EVT_EN, 32'h0000_0001, 4'h3);
    @(posedge clk_sys) link_up <= 1'b1;
    tick(3);
    chk({31'h0, mgmt_irq_pin}, 32'h1);
    // One rise at the first enable write, fourteen in the loop, one for link
    chk(rise_cnt, 32'h0000_0010);
  endtask : t_events
  task report_and_stop;
    $display("Checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_status();
    t_enable();
    t_events();
    report_and_stop();
  end
  // Watchdog well past the few hundred cycles the tests need
  initial begin
    #50000;
    err_count++;
    $display("Error %0t: timeout", $time);
    report_and_stop();
  end
endmodule : testbench
